// ### hdl/prescale_if.sv
`timescale 1ns/1ns
interface prescale_if;
	logic       clear;
	logic       tick;
	logic [2:0] rate;
	logic       out;

	modport ctl
	(
		output clear,
		output tick,
		output rate,
		input  out
	);

	modport pre
	(
		input  clear,
		input  tick,
		input  rate,
		output out
	);
endinterface

// ### hdl/prescaler8.sv
`timescale 1ns/1ns
module prescaler8
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// control from the counter
	prescale_if.pre   div_bus
);

	logic [7:0] div_count;
	logic [7:0] next_div_count;
	logic       out_q;
	logic       next_out_q;

	// out is bit rate of the divider: a square wave of period 2 << rate ticks
	always_comb
	begin
		next_div_count = div_count;
		if (div_bus.clear)
		begin
			next_div_count = 8'h00;
		end
		else if (div_bus.tick)
		begin
			next_div_count = div_count + 8'h01;
		end
		next_out_q = next_div_count[div_bus.rate];
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			div_count <= 8'h00;
			out_q     <= 1'b0;
		end
		else
		begin
			div_count <= next_div_count;
			out_q     <= next_out_q;
		end
	end

	assign div_bus.out = out_q;

endmodule

// ### hdl/timer8.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
// What this block does
// - one 8-bit count register, readable and writable, timer or counter.
// - source select clear and prescaler bypassed: count once per instruction cycle.
// - after a count register write, increments are held off two instruction cycles.
// - source select set: count chosen edges of the external count input.
// - edge select bit chooses rising or falling pin transition.
// - prescaler sits in the count path only while bypass is clear.
// - eight prescale ratios from divide by 2 to divide by 256.
// - a 1:1 rate comes only from setting the bypass bit.
// - prescaler count is hidden and cleared by every count register write.
// - overflow flag sets when the count wraps from ff to 00.
// - overflow flag sets on every wrap regardless of interrupt enable.
// - hardware never clears the overflow flag; only software writes do.
// - overflow interrupt requested only while its enable bit is set.
// - counting stops in sleep, so no overflow can occur there.
// - the 8-bit prescaler belongs to this counter alone, not the watchdog.
// - overflow event is exported as a gate source for the 16-bit timer.
// - rate code 000 divides by 2, each step doubles, 111 by 256.
// - edge select set counts high-to-low, clear counts low-to-high.
// - counter mode samples the prescaler output, or the pin when bypassed, at quarter phases two and four.
// - count register holds its value throughout sleep unless a register write loads it.
module timer8
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// register port
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// pins and system
	input  wire logic       external_count_input_i,
	input  wire logic       sleep_i,
	// outputs
	output logic            overflow_irq_o,
	output logic            overflow_event_o
);

	// registers
	logic [7:0]                  timer_count;
	logic [7:0]                  next_timer_count;
	logic                        count_source_select;
	logic                        source_edge_select;
	logic                        prescaler_bypass;
	logic [2:0]                  prescale_rate;
	logic [5:0]                  next_option;
	logic                        overflow_irq_enable;
	logic                        next_overflow_irq_enable;
	logic                        overflow_flag;
	logic                        next_overflow_flag;
	logic [7:0]                  next_rdata;
	logic                        next_overflow_event;

	// timing and edge state
	logic [1:0]                  phase;
	logic [1:0]                  next_phase;
	logic                        pin_level_prev;
	logic                        next_pin_level_prev;
	logic                        sampled;
	logic                        next_sampled;
	timer8_pkg::hold_state_t     hold_state;
	timer8_pkg::hold_state_t     next_hold_state;

	// decoded strobes and events
	logic                        count_wr;
	logic                        option_wr;
	logic                        intctl_wr;
	logic                        instr_en;
	logic                        pin_level;
	logic                        ext_edge;
	logic                        sample_now;
	logic                        pre_level;
	logic                        sync_rise;
	logic                        inc_req;
	logic                        inc;
	logic                        overflow_evt;

	prescale_if div_bus ();

	function automatic logic is_addr(input logic [1:0] a, input logic [1:0] target);
		is_addr = (a == target);
	endfunction

	assign count_wr  = wr_i && is_addr(addr_i, timer8_pkg::ADDR_COUNT);
	assign option_wr = wr_i && is_addr(addr_i, timer8_pkg::ADDR_OPTION);
	assign intctl_wr = wr_i && is_addr(addr_i, timer8_pkg::ADDR_INTCTL);

	// instruction cycle phases; phase and counting freeze in sleep, register writes still act
	assign instr_en = !sleep_i && (phase == timer8_pkg::PHASE_Q4);

	// inverting the pin makes the chosen edge always a rising one
	assign pin_level = external_count_input_i ^ source_edge_select;
	assign ext_edge  = !sleep_i && pin_level && !pin_level_prev;

	// prescaler ticks on the selected source only when assigned here
	assign div_bus.tick  = !prescaler_bypass &&
		(count_source_select ? ext_edge : instr_en);
	assign div_bus.clear = count_wr;
	assign div_bus.rate  = prescale_rate;

	// bypass gives the raw edge-corrected pin, the only way to reach 1:1
	assign pre_level = prescaler_bypass ? pin_level : div_bus.out;

	// bypassed pin or prescaler output sampled only at Q2 and Q4, which bounds the usable pin rate
	assign sample_now = !sleep_i &&
		(phase == timer8_pkg::PHASE_Q2 || phase == timer8_pkg::PHASE_Q4);
	assign sync_rise  = sample_now && pre_level && !sampled;

	always_comb
	begin
		if (count_source_select || !prescaler_bypass)
		begin
			inc_req = sync_rise;
		end
		else
		begin
			inc_req = instr_en;
		end
	end

	// write wins over the increment in the same cycle
	assign inc          = inc_req && !sleep_i && !count_wr &&
		(hold_state == timer8_pkg::HOLD_IDLE);
	assign overflow_evt = inc && (timer_count == timer8_pkg::COUNT_MAX);

	prescaler8 u_prescaler
	(
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.div_bus  (div_bus.pre)
	);

	// phase and edge tracking
	always_comb
	begin
		next_phase          = sleep_i ? phase : phase + 2'h1;
		next_pin_level_prev = sleep_i ? pin_level_prev : pin_level;
		next_sampled        = sampled;
		if (count_wr)
		begin
			next_sampled = 1'b0;
		end
		else if (sample_now)
		begin
			next_sampled = pre_level;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			phase          <= 2'h0;
			// start high so a pin idling at either level cannot fake an edge after reset
			pin_level_prev <= 1'b1;
			sampled        <= 1'b1;
		end
		else
		begin
			phase          <= next_phase;
			pin_level_prev <= next_pin_level_prev;
			sampled        <= next_sampled;
		end
	end

	// post-write holdoff: two instruction boundaries must pass
	always_comb
	begin
		next_hold_state = hold_state;
		if (count_wr)
		begin
			next_hold_state = timer8_pkg::HOLD_FIRST;
		end
		else
		begin
			case (hold_state)
				timer8_pkg::HOLD_IDLE:
				begin
					next_hold_state = timer8_pkg::HOLD_IDLE;
				end
				timer8_pkg::HOLD_FIRST:
				begin
					if (instr_en)
					begin
						next_hold_state = timer8_pkg::HOLD_SECOND;
					end
				end
				timer8_pkg::HOLD_SECOND:
				begin
					if (instr_en)
					begin
						next_hold_state = timer8_pkg::HOLD_IDLE;
					end
				end
				default:
				begin
					next_hold_state = timer8_pkg::HOLD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			hold_state <= timer8_pkg::HOLD_IDLE;
		end
		else
		begin
			hold_state <= next_hold_state;
		end
	end

	// count, configuration and flag
	always_comb
	begin
		next_timer_count = timer_count;
		if (count_wr)
		begin
			next_timer_count = wdata_i;
		end
		else if (inc)
		begin
			next_timer_count = timer_count + 8'h01;
		end

		next_option = {count_source_select, source_edge_select, prescaler_bypass,
			prescale_rate};
		if (option_wr)
		begin
			next_option = wdata_i[timer8_pkg::SRC_SEL_BIT:timer8_pkg::RATE_LSB];
		end

		next_overflow_irq_enable = overflow_irq_enable;
		next_overflow_flag       = overflow_flag;
		if (intctl_wr)
		begin
			next_overflow_irq_enable = wdata_i[timer8_pkg::IRQ_EN_BIT];
			next_overflow_flag       = wdata_i[timer8_pkg::FLAG_BIT];
		end
		// a wrap in the clearing cycle still sets the flag
		if (overflow_evt)
		begin
			next_overflow_flag = 1'b1;
		end
		next_overflow_event = overflow_evt;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			timer_count         <= timer8_pkg::COUNT_RESET;
			{count_source_select, source_edge_select, prescaler_bypass, prescale_rate}
				<= timer8_pkg::OPTION_RESET;
			overflow_irq_enable <= timer8_pkg::IRQ_EN_RESET;
			overflow_flag       <= timer8_pkg::FLAG_RESET;
			overflow_event_o    <= 1'b0;
		end
		else
		begin
			timer_count         <= next_timer_count;
			{count_source_select, source_edge_select, prescaler_bypass, prescale_rate}
				<= next_option;
			overflow_irq_enable <= next_overflow_irq_enable;
			overflow_flag       <= next_overflow_flag;
			overflow_event_o    <= next_overflow_event;
		end
	end

	assign overflow_irq_o = overflow_flag && overflow_irq_enable;

	// read data stand only in the cycle after the read strobe
	always_comb
	begin
		next_rdata = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				timer8_pkg::ADDR_COUNT:
				begin
					next_rdata = timer_count;
				end
				timer8_pkg::ADDR_OPTION:
				begin
					next_rdata = {2'h0, count_source_select, source_edge_select,
						prescaler_bypass, prescale_rate};
				end
				timer8_pkg::ADDR_INTCTL:
				begin
					next_rdata[timer8_pkg::IRQ_EN_BIT] = overflow_irq_enable;
					next_rdata[timer8_pkg::FLAG_BIT]   = overflow_flag;
				end
				default:
				begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rdata_o <= 8'h00;
		end
		else
		begin
			rdata_o <= next_rdata;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	write_loads_a: assert property (count_wr |=> timer_count == $past(wdata_i))
		else $error("count write did not load the written value");

	write_holdoff_a: assert property (
		count_wr ##1 (!count_wr && !sleep_i) |-> (hold_state != timer8_pkg::HOLD_IDLE)
			##1 $stable(timer_count))
		else $error("count moved right after a write");

	holdoff_ends_a: assert property (
		count_wr ##1 (!count_wr && !sleep_i)[*8] |=> hold_state == timer8_pkg::HOLD_IDLE)
		else $error("holdoff outlasted two instruction cycles");

	wrap_sets_flag_a: assert property (
		inc && timer_count == 8'hff |=> overflow_flag && timer_count == 8'h00)
		else $error("wrap did not set overflow flag");

	flag_sticks_a: assert property (overflow_flag && !intctl_wr |=> overflow_flag)
		else $error("overflow flag cleared by hardware");

	irq_gated_a: assert property (!overflow_irq_enable |-> !overflow_irq_o)
		else $error("interrupt raised while disabled");

	sleep_freeze_a: assert property (sleep_i && !count_wr |=> $stable(timer_count))
		else $error("count changed during sleep");

	timer_step_a: assert property (
		!count_source_select && prescaler_bypass && instr_en && !count_wr
			&& hold_state == timer8_pkg::HOLD_IDLE
		|=> timer_count == 8'($past(timer_count) + 8'h01))
		else $error("timer mode missed an instruction cycle");

	phase_sample_a: assert property (
		count_source_select && !count_wr && !sample_now |=> $stable(timer_count))
		else $error("counter mode stepped outside Q2 and Q4");

	event_pulse_a: assert property (
		overflow_evt |=> overflow_event_o ##1 !overflow_event_o)
		else $error("overflow event not a single pulse");

	read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data present without a read");

endmodule

// ### hdl/timer8_pkg.sv
package timer8_pkg;

	// register map of the plain register port
	localparam int          ADDR_W          = 2;
	localparam logic [1:0]  ADDR_COUNT      = 2'h0;
	localparam logic [1:0]  ADDR_OPTION     = 2'h1;
	localparam logic [1:0]  ADDR_INTCTL     = 2'h2;

	// option register fields
	localparam int          SRC_SEL_BIT     = 5;
	localparam int          EDGE_SEL_BIT    = 4;
	localparam int          BYPASS_BIT      = 3;
	localparam int          RATE_LSB        = 0;
	localparam int          RATE_W          = 3;

	// interrupt control register fields
	localparam int          IRQ_EN_BIT      = 5;
	localparam int          FLAG_BIT        = 2;

	// reset values
	localparam logic [7:0]  COUNT_RESET     = 8'h00;
	localparam logic [5:0]  OPTION_RESET    = 6'h3f;
	localparam logic        IRQ_EN_RESET    = 1'h0;
	localparam logic        FLAG_RESET      = 1'h0;

	// instruction cycle is four clocks, quarter phases 0..3
	localparam logic [1:0]  PHASE_Q2        = 2'h1;
	localparam logic [1:0]  PHASE_Q4        = 2'h3;
	localparam logic [7:0]  COUNT_MAX       = 8'hff;

	typedef enum logic [2:0]
	{
		HOLD_IDLE   = 3'b001,
		HOLD_FIRST  = 3'b010,
		HOLD_SECOND = 3'b100
	} hold_state_t;

endpackage

// ### tb/eight_bit_timer_counter_test.sv
`timescale 1ns/1ns
module eight_bit_timer_counter_test;
	logic       clk_i    = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [1:0] addr     = 2'h0;
	logic [7:0] wdata    = 8'h00;
	logic       wr       = 1'b0;
	logic       rd       = 1'b0;
	logic       sleep    = 1'b0;
	logic       start    = 1'b0;
	logic [7:0] n_pulse  = 8'h00;
	logic       idle     = 1'b0;
	logic [7:0] rdata;
	logic       pin;
	logic       busy;
	logic       irq;
	logic       evt;
	logic [7:0] x;
	logic [7:0] v;
	int         k;
	int         n_mismatch  = 0;
	int         comparisons = 0;
	int         cycles      = 0;

	always #4 clk_i = ~clk_i;

	timer8 uut
	(
		.clk_i                  (clk_i),
		.arst_n_i               (arst_n_i),
		.addr_i                 (addr),
		.wdata_i                (wdata),
		.wr_i                   (wr),
		.rd_i                   (rd),
		.rdata_o                (rdata),
		.external_count_input_i (pin),
		.sleep_i                (sleep),
		.overflow_irq_o         (irq),
		.overflow_event_o       (evt)
	);

	pulse_src src
	(
		.clk_i   (clk_i),
		.start_i (start),
		.n_i     (n_pulse),
		.idle_i  (idle),
		.pin_o   (pin),
		.busy_o  (busy)
	);

	function automatic logic [7:0] timer_exp(input logic [7:0] w, input int cyc);
		// two instruction cycles after a write are lost to the hold-off
		return w + 8'(cyc - 2);
	endfunction

	task automatic report_and_stop();
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		comparisons++;
		if (!(got >= lo && got <= hi) || $isunknown(got))
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr    <= 1'b0;
		// one idle edge so a following call never reassigns the strobe in the same step
		@(posedge clk_i);
	endtask

	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd   <= 1'b0;
		@(negedge clk_i);
		d = rdata;
		@(posedge clk_i);
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	task automatic burst(input int n);
		start   <= 1'b1;
		n_pulse <= 8'(n);
		@(posedge clk_i);
		start   <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 600 && busy !== 1'b0; i++)
			@(posedge clk_i);
		repeat (8) @(posedge clk_i);
	endtask

	// cycle ceiling, well above the longest sequence below
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial
	begin
		void'($urandom(26070));
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		rd_chk(timer8_pkg::ADDR_COUNT, timer8_pkg::COUNT_RESET);
		rd_chk(timer8_pkg::ADDR_OPTION, {2'h0, timer8_pkg::OPTION_RESET});
		rd_chk(timer8_pkg::ADDR_INTCTL, 8'h00);
		wr_reg(2'h3, 8'ha5);
		rd_chk(2'h3, 8'h00);
		wr_reg(timer8_pkg::ADDR_OPTION, 8'hff);
		rd_chk(timer8_pkg::ADDR_OPTION, 8'h3f);
		// timer mode without prescaler, random loads, hold-off after each
		wr_reg(timer8_pkg::ADDR_OPTION, 8'h08);
		for (int i = 0; i < 6; i++)
		begin
			x = 8'($urandom);
			k = 3 + int'($urandom % 8);
			wr_reg(timer8_pkg::ADDR_COUNT, x);
			repeat (4 * k - 1) @(posedge clk_i);
			rd_chk(timer8_pkg::ADDR_COUNT, timer_exp(x, k));
		end
		// overflow with the interrupt disabled, then enabled, then cleared
		wr_reg(timer8_pkg::ADDR_INTCTL, 8'h00);
		wr_reg(timer8_pkg::ADDR_COUNT, 8'hff);
		k = 0;
		do
		begin
			@(negedge clk_i);
			k++;
		end
		while (evt !== 1'b1 && k < 20);
		chk({7'h0, evt}, 8'h01);
		chk({7'h0, irq}, 8'h00);
		@(negedge clk_i);
		chk({7'h0, evt}, 8'h00);
		@(posedge clk_i);
		rd_chk(timer8_pkg::ADDR_INTCTL, 8'h04);
		repeat (40) @(posedge clk_i);
		rd_chk(timer8_pkg::ADDR_INTCTL, 8'h04);
		wr_reg(timer8_pkg::ADDR_INTCTL, 8'h24);
		@(negedge clk_i);
		chk({7'h0, irq}, 8'h01);
		wr_reg(timer8_pkg::ADDR_INTCTL, 8'h20);
		@(negedge clk_i);
		chk({7'h0, irq}, 8'h00);
		rd_chk(timer8_pkg::ADDR_INTCTL, 8'h20);
		// sleep freezes the count, so no wrap can happen
		wr_reg(timer8_pkg::ADDR_INTCTL, 8'h00);
		wr_reg(timer8_pkg::ADDR_COUNT, 8'hff);
		sleep <= 1'b1;
		repeat (40) @(posedge clk_i);
		rd_chk(timer8_pkg::ADDR_COUNT, 8'hff);
		rd_chk(timer8_pkg::ADDR_INTCTL, 8'h00);
		sleep <= 1'b0;
		// every prescale code over eight periods; sync delay may lose up to two
		for (int r = 0; r < 8; r++)
		begin
			wr_reg(timer8_pkg::ADDR_OPTION, 8'(r));
			wr_reg(timer8_pkg::ADDR_COUNT, 8'h00);
			repeat (32 * (2 << r)) @(posedge clk_i);
			rd_reg(timer8_pkg::ADDR_COUNT, v);
			chk_rng(v, 8'h06, 8'h08);
		end
		// pin mode through the divide-by-2 prescaler: eight edges, four counts
		wr_reg(timer8_pkg::ADDR_OPTION, 8'h20);
		wr_reg(timer8_pkg::ADDR_COUNT, 8'h00);
		// edges arriving inside the hold-off would be lost
		repeat (12) @(posedge clk_i);
		burst(8);
		rd_chk(timer8_pkg::ADDR_COUNT, 8'h04);
		// pin mode, rising then falling edges; idle level set so no edge is invented
		for (int e = 0; e < 2; e++)
		begin
			wr_reg(timer8_pkg::ADDR_OPTION, (e == 1) ? 8'h38 : 8'h28);
			idle <= (e == 1);
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < 3; i++)
			begin
				wr_reg(timer8_pkg::ADDR_COUNT, 8'h00);
				repeat (12) @(posedge clk_i);
				k = 1 + int'($urandom % 20);
				burst(k);
				rd_chk(timer8_pkg::ADDR_COUNT, 8'(k));
			end
		end
		report_and_stop();
	end
endmodule

// ### tb/pulse_src.sv
`timescale 1ns/1ns
// far-side pulse source on the count pin; rests at its idle level between bursts
module pulse_src
(
	// clock
	input  wire logic       clk_i,
	// control from the bench
	input  wire logic       start_i,
	input  wire logic [7:0] n_i,
	input  wire logic       idle_i,
	// pin
	output logic            pin_o,
	output logic            busy_o
);
	logic [8:0] edges = 9'h0;
	logic [1:0] cnt   = 2'h0;

	initial pin_o = 1'b0;

	// half period of four clocks keeps every level past one q2/q4 sample
	always @(posedge clk_i)
	begin
		cnt <= cnt + 2'h1;
		if (start_i)
		begin
			edges <= {n_i, 1'b0};
			cnt   <= 2'h0;
		end
		else if (edges == 9'h0)
			pin_o <= idle_i;
		else if (cnt == 2'h3)
		begin
			pin_o <= ~pin_o;
			edges <= edges - 9'h1;
		end
	end

	assign busy_o = (edges != 9'h0);
endmodule
